// >>> scpb_pkg.sv
package scpb_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ************************************************************
  // parameter numbers (word index on the parameter link)
  // ************************************************************
  localparam logic [7:0] IDX_ENCODER_KIND   = 8'h01;
  localparam logic [7:0] IDX_MOTOR_KIND     = 8'h02;
  localparam logic [7:0] IDX_LOOP_KIND      = 8'h03;
  localparam logic [7:0] IDX_RATED_SPEED    = 8'h04;
  localparam logic [7:0] IDX_PEAK_SPEED     = 8'h05;
  localparam logic [7:0] IDX_SPEED_SCALE    = 8'h06;
  localparam logic [7:0] IDX_RATED_FORCE    = 8'h07;
  localparam logic [7:0] IDX_PEAK_FORCE     = 8'h08;
  localparam logic [7:0] IDX_FORCE_SCALE    = 8'h09;
  localparam logic [7:0] IDX_SCALE_PITCH    = 8'h0b;
  localparam logic [7:0] IDX_PULSES_PITCH   = 8'h0c;
  localparam logic [7:0] IDX_GEAR_NUM       = 8'h21;
  localparam logic [7:0] IDX_GEAR_DEN       = 8'h22;
  localparam logic [7:0] IDX_ORIGIN_OFFSET  = 8'h23;
  localparam logic [7:0] IDX_LIMIT_CONFIG   = 8'h25;
  localparam logic [7:0] IDX_FWD_SOFT_LIMIT = 8'h26;
  localparam logic [7:0] IDX_RSVD_AFTER_FWD = 8'h27;

  // ************************************************************
  // reset values and ranges
  // ************************************************************
  localparam logic [31:0] RST_ENCODER_KIND   = 32'h0000_0001;
  localparam logic [31:0] RST_SCALE_PITCH    = 32'h0000_0000;
  localparam logic [31:0] RST_GEAR           = 32'h0000_0001;
  localparam logic [31:0] RST_ORIGIN_OFFSET  = 32'h0000_0000;
  localparam logic [31:0] RST_LIMIT_CONFIG   = 32'h0000_0000;
  localparam logic [31:0] RST_FWD_SOFT_LIMIT = 32'h3fff_ffff;
  localparam logic [31:0] RSVD_VALUE         = 32'h0000_0000;
  localparam logic [31:0] GEAR_MIN           = 32'h0000_0001;
  localparam logic [31:0] GEAR_MAX           = 32'h4000_0000;
  localparam logic [31:0] PITCH_MAX          = 32'h03e8_0000;
  localparam logic [31:0] PITCH_STEP         = 32'h0000_000a;
  localparam logic [31:0] SIGNED_MAX         = 32'h3fff_ffff;
  localparam logic [31:0] SIGNED_MIN         = 32'hc000_0001;
  localparam logic [31:0] FORCE_MAX          = 32'h0fff_ffff;

  // ************************************************************
  // limit settings word layout
  // ************************************************************
  localparam int LIM_POS_OT_OFF  = 0;
  localparam int LIM_NEG_OT_OFF  = 1;
  localparam int LIM_POS_SOFT_EN = 4;
  localparam int LIM_NEG_SOFT_EN = 5;
  localparam logic [31:0] LIM_MASK = 32'h0000_0033;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] idx;
    logic [DATA_W-1:0] wdata;
  } scpb_req_t;

  typedef struct packed {
    logic [31:0] scale_pitch;
    logic [31:0] gear_num;
    logic [31:0] gear_den;
    logic [31:0] limit_config;
  } scpb_restart_set_t;

  // device information supplied by the drive itself
  typedef struct packed {
    logic [31:0] motor_kind;
    logic [31:0] loop_kind;
    logic [31:0] rated_speed;
    logic [31:0] peak_speed;
    logic [31:0] speed_scale;
    logic [31:0] rated_force;
    logic [31:0] peak_force;
    logic [31:0] force_scale;
    logic [31:0] pulses_pitch;
  } scpb_dev_info_t;

  typedef enum logic [1:0] {
    RSP_OK,
    RSP_READ_ONLY,
    RSP_RANGE,
    RSP_UNMAPPED
  } scpb_status_t;

endpackage

// >>> scpb_shadow.sv
`timescale 1ns/100ps
// pending/effective pair for one restart-enabled parameter
module scpb_shadow #(
  parameter logic [31:0] RESET_VALUE = 32'h0000_0000
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        load,
  input  wire logic [31:0] load_value,
  input  wire logic        commit,
  output logic      [31:0] pending,
  output logic      [31:0] effective
);

  // a load in the commit cycle is caught up so the new value is committed
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pending <= RESET_VALUE;
    end else if (load) begin
      pending <= load_value;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      effective <= RESET_VALUE;
    end else if (commit) begin
      effective <= load ? load_value : pending;
    end
  end

endmodule

// >>> scpb_param_bank.sv
`timescale 1ns/100ps
// Notes on behaviour
// RQ1: only the host over the network link changes these parameters.
// RQ2: restart-enabled settings keep their old effect until a config command.
// RQ3: the host writes scale pitch 0..65536000 as a multiple of 10.
// RQ4: peak force reads back as a read-only value limited to 0..FFFFFFFh.
// RQ5: peak speed in mm/s reads back read-only.
// RQ6: pulses per scale pitch reads back read-only.
// RQ7: gear numerator accepts 1..1073741824, resets to 1, applies on restart.
// RQ8: gear denominator accepts 1..1073741824, resets to 1, applies on restart.
// RQ9: origin offset is signed +-1073741823, resets to 0, applies at once.
// RQ10: limit bit 0 set disables the positive overtravel input.
// RQ11: limit bit 1 set disables the negative overtravel input.
// RQ12: limit bit 4 set enables the positive software limit.
// RQ13: limit bit 5 set enables the negative software limit.
// RQ14: the reserved word after the forward limit always reads zero.
// RQ15: writes to device information leave it unchanged.
module scpb_param_bank
  import scpb_pkg::*;
(
  input  wire logic                        CLK,
  input  wire logic                        RESET,
  input  wire scpb_pkg::scpb_req_t         REQ,
  input  wire logic                        CONFIG_CMD,
  input  wire scpb_pkg::scpb_dev_info_t    DEV_INFO,
  output logic                             RSP_VALID,
  output scpb_pkg::scpb_status_t           RSP_STATUS,
  output logic [scpb_pkg::DATA_W-1:0]      RSP_RDATA,
  output scpb_pkg::scpb_restart_set_t      EFFECTIVE,
  output logic [31:0]                      ORIGIN_OFFSET,
  output logic [31:0]                      FWD_SOFT_LIMIT,
  output logic                             POS_OVERTRAVEL_INPUT_EN,
  output logic                             NEG_OVERTRAVEL_INPUT_EN,
  output logic                             POS_SOFTWARE_LIMIT_EN,
  output logic                             NEG_SOFTWARE_LIMIT_EN
);
  import scpb_pkg::*;

  // ************************************************************
  // address decode
  // ************************************************************
  wire logic [7:0] idx;
  wire logic       acc;
  wire logic       hit_pitch;
  wire logic       hit_num;
  wire logic       hit_den;
  wire logic       hit_origin;
  wire logic       hit_limit;
  wire logic       hit_fwd;
  wire logic       hit_rsvd;
  wire logic       hit_ro;
  wire logic       mapped;
  wire logic [31:0] wd;

  assign idx        = REQ.idx;
  assign wd         = REQ.wdata;
  assign acc        = REQ.wr | REQ.rd;
  assign hit_pitch  = (idx == IDX_SCALE_PITCH);
  assign hit_num    = (idx == IDX_GEAR_NUM);
  assign hit_den    = (idx == IDX_GEAR_DEN);
  assign hit_origin = (idx == IDX_ORIGIN_OFFSET);
  assign hit_limit  = (idx == IDX_LIMIT_CONFIG);
  assign hit_fwd    = (idx == IDX_FWD_SOFT_LIMIT);
  assign hit_rsvd   = (idx == IDX_RSVD_AFTER_FWD);
  assign hit_ro     = (idx >= IDX_ENCODER_KIND && idx <= IDX_FORCE_SCALE)
                    || (idx == IDX_PULSES_PITCH);
  assign mapped     = hit_ro | hit_pitch | hit_num | hit_den | hit_origin
                    | hit_limit | hit_fwd | hit_rsvd;

  // ************************************************************
  // range checks
  // ************************************************************
  wire logic pitch_ok;
  wire logic gear_ok;
  wire logic signed_ok;
  wire logic [31:0] pitch_rem;

  // a constant-divisor modulo keeps the multiple-of-ten check exact
  assign pitch_rem = wd % PITCH_STEP;
  assign pitch_ok  = (wd <= PITCH_MAX) && (pitch_rem == '0); // RQ3
  assign gear_ok   = (wd >= GEAR_MIN) && (wd <= GEAR_MAX); // RQ7 RQ8
  assign signed_ok = ($signed(wd) <= $signed(SIGNED_MAX))
                   && ($signed(wd) >= $signed(SIGNED_MIN)); // RQ9

  wire logic value_ok;
  assign value_ok = hit_pitch ? pitch_ok
                  : (hit_num | hit_den) ? gear_ok
                  : (hit_origin | hit_fwd) ? signed_ok
                  : hit_limit ? ((wd & ~LIM_MASK) == '0)
                  : 1'b1;

  // only the network link reaches these stores; no other writer exists
  wire logic wr_ok;
  assign wr_ok = REQ.wr & value_ok & ~hit_ro & ~hit_rsvd; // RQ1 RQ15 RQ14

  // ************************************************************
  // restart-enabled settings
  // ************************************************************
  wire logic [31:0] pend_pitch;
  wire logic [31:0] pend_num;
  wire logic [31:0] pend_den;
  wire logic [31:0] pend_limit;
  wire logic [31:0] eff_pitch;
  wire logic [31:0] eff_num;
  wire logic [31:0] eff_den;
  wire logic [31:0] eff_limit;

  // reads return the stored setting; its effect waits for the command
  scpb_shadow #(.RESET_VALUE(RST_SCALE_PITCH)) u_pitch ( // RQ2
    .CLK        (CLK),
    .RESET      (RESET),
    .load       (wr_ok & hit_pitch),
    .load_value (wd),
    .commit     (CONFIG_CMD),
    .pending    (pend_pitch),
    .effective  (eff_pitch)
  );

  scpb_shadow #(.RESET_VALUE(RST_GEAR)) u_num ( // RQ7
    .CLK        (CLK),
    .RESET      (RESET),
    .load       (wr_ok & hit_num),
    .load_value (wd),
    .commit     (CONFIG_CMD),
    .pending    (pend_num),
    .effective  (eff_num)
  );

  scpb_shadow #(.RESET_VALUE(RST_GEAR)) u_den ( // RQ8
    .CLK        (CLK),
    .RESET      (RESET),
    .load       (wr_ok & hit_den),
    .load_value (wd),
    .commit     (CONFIG_CMD),
    .pending    (pend_den),
    .effective  (eff_den)
  );

  scpb_shadow #(.RESET_VALUE(RST_LIMIT_CONFIG)) u_limit ( // RQ2
    .CLK        (CLK),
    .RESET      (RESET),
    .load       (wr_ok & hit_limit),
    .load_value (wd & LIM_MASK),
    .commit     (CONFIG_CMD),
    .pending    (pend_limit),
    .effective  (eff_limit)
  );

  // ************************************************************
  // immediate settings
  // ************************************************************
  logic [31:0] origin;
  logic [31:0] fwd_limit;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      origin <= RST_ORIGIN_OFFSET;
    end else if (wr_ok && hit_origin) begin
      origin <= wd; // RQ9
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      fwd_limit <= RST_FWD_SOFT_LIMIT;
    end else if (wr_ok && hit_fwd) begin
      fwd_limit <= wd;
    end
  end

  // ************************************************************
  // read mux
  // ************************************************************
  wire logic [31:0] peak_force_clip;
  wire logic [31:0] rd_value;

  // clipping protects the host from an out-of-range report
  assign peak_force_clip = (DEV_INFO.peak_force > FORCE_MAX)
                         ? FORCE_MAX : DEV_INFO.peak_force; // RQ4

  assign rd_value =
      (idx == IDX_ENCODER_KIND)   ? RST_ENCODER_KIND
    : (idx == IDX_MOTOR_KIND)     ? DEV_INFO.motor_kind
    : (idx == IDX_LOOP_KIND)      ? DEV_INFO.loop_kind
    : (idx == IDX_RATED_SPEED)    ? DEV_INFO.rated_speed
    : (idx == IDX_PEAK_SPEED)     ? DEV_INFO.peak_speed // RQ5
    : (idx == IDX_SPEED_SCALE)    ? DEV_INFO.speed_scale
    : (idx == IDX_RATED_FORCE)    ? DEV_INFO.rated_force
    : (idx == IDX_PEAK_FORCE)     ? peak_force_clip
    : (idx == IDX_FORCE_SCALE)    ? DEV_INFO.force_scale
    : (idx == IDX_PULSES_PITCH)   ? DEV_INFO.pulses_pitch // RQ6
    : hit_pitch                   ? pend_pitch
    : hit_num                     ? pend_num
    : hit_den                     ? pend_den
    : hit_origin                  ? origin
    : hit_limit                   ? pend_limit
    : hit_fwd                     ? fwd_limit
    : RSVD_VALUE; // RQ14

  scpb_status_t next_status;
  always_comb begin
    next_status = RSP_OK;
    if (!mapped) begin
      next_status = RSP_UNMAPPED;
    end else if (REQ.wr && (hit_ro || hit_rsvd)) begin
      next_status = RSP_READ_ONLY; // RQ15
    end else if (REQ.wr && !value_ok) begin
      next_status = RSP_RANGE;
    end
  end

  // ************************************************************
  // response and output registers
  // ************************************************************
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RSP_VALID  <= 1'b0;
      RSP_STATUS <= RSP_OK;
      RSP_RDATA  <= '0;
    end else begin
      RSP_VALID  <= acc;
      if (acc) begin
        RSP_STATUS <= next_status;
        RSP_RDATA  <= (REQ.rd && mapped) ? rd_value : '0;
      end
    end
  end

  // outputs re-registered so every port leaves a flip-flop directly
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      EFFECTIVE               <= '{RST_SCALE_PITCH, RST_GEAR, RST_GEAR,
                                   RST_LIMIT_CONFIG};
      ORIGIN_OFFSET           <= RST_ORIGIN_OFFSET;
      FWD_SOFT_LIMIT          <= RST_FWD_SOFT_LIMIT;
      POS_OVERTRAVEL_INPUT_EN <= 1'b1;
      NEG_OVERTRAVEL_INPUT_EN <= 1'b1;
      POS_SOFTWARE_LIMIT_EN   <= 1'b0;
      NEG_SOFTWARE_LIMIT_EN   <= 1'b0;
    end else begin
      EFFECTIVE               <= '{eff_pitch, eff_num, eff_den, eff_limit};
      ORIGIN_OFFSET           <= origin;
      FWD_SOFT_LIMIT          <= fwd_limit;
      POS_OVERTRAVEL_INPUT_EN <= ~eff_limit[LIM_POS_OT_OFF]; // RQ10
      NEG_OVERTRAVEL_INPUT_EN <= ~eff_limit[LIM_NEG_OT_OFF]; // RQ11
      POS_SOFTWARE_LIMIT_EN   <= eff_limit[LIM_POS_SOFT_EN]; // RQ12
      NEG_SOFTWARE_LIMIT_EN   <= eff_limit[LIM_NEG_SOFT_EN]; // RQ13
    end
  end

endmodule

// >>> scpb_monitor.sv
`timescale 1ns/100ps
// ********
// parameter bank checker
// ********
module scpb_monitor
  import scpb_pkg::*;
(
  input wire logic                        CLK,
  input wire logic                        RESET,
  input wire scpb_pkg::scpb_req_t         REQ,
  input wire logic                        CONFIG_CMD,
  input wire scpb_pkg::scpb_dev_info_t    DEV_INFO,
  input wire logic                        RSP_VALID,
  input wire scpb_pkg::scpb_status_t      RSP_STATUS,
  input wire logic [scpb_pkg::DATA_W-1:0] RSP_RDATA,
  input wire scpb_pkg::scpb_restart_set_t EFFECTIVE,
  input wire logic [31:0]                 ORIGIN_OFFSET,
  input wire logic                        POS_OVERTRAVEL_INPUT_EN,
  input wire logic                        NEG_OVERTRAVEL_INPUT_EN,
  input wire logic                        POS_SOFTWARE_LIMIT_EN,
  input wire logic                        NEG_SOFTWARE_LIMIT_EN
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  wire ro_idx = REQ.idx inside {[8'h01:8'h09], 8'h0c, 8'h27};
  wire gear_idx = REQ.idx inside {IDX_GEAR_NUM, IDX_GEAR_DEN};
  wire org_wr = REQ.wr && REQ.idx == IDX_ORIGIN_OFFSET;
  wire signed [31:0] wd = REQ.wdata;
  wire org_ok = wd >= -32'sd1073741823 && wd <= 32'sd1073741823;
  // peak force wider than the documented field is reported saturated
  wire [31:0] clip = DEV_INFO.peak_force > FORCE_MAX ? FORCE_MAX
                                                     : DEV_INFO.peak_force;
  AST_RO_REFUSE:
    assert property (REQ.wr && ro_idx |=> RSP_STATUS == RSP_READ_ONLY)
    else $error("read-only write not refused");
  AST_GEAR_RANGE:
    assert property (REQ.wr && gear_idx && (REQ.wdata == 0 ||
      REQ.wdata > GEAR_MAX) |=> RSP_VALID && RSP_STATUS == RSP_RANGE)
    else $error("gear value out of range accepted");
  AST_RESTART_HOLD:
    assert property ($changed(EFFECTIVE) |-> $past(CONFIG_CMD, 2))
    else $error("effective setting moved without config");
  AST_ORIGIN_NOW:
    assert property (org_wr && org_ok |->
      ##2 ORIGIN_OFFSET == $past(REQ.wdata, 2))
    else $error("origin offset not applied at once");
  AST_ORIGIN_RANGE:
    assert property (org_wr && !org_ok |=>
      RSP_STATUS == RSP_RANGE ##1 $stable(ORIGIN_OFFSET))
    else $error("origin offset out of range taken");
  AST_POS_OT:
    assert property (POS_OVERTRAVEL_INPUT_EN == !EFFECTIVE.limit_config[0])
    else $error("positive overtravel enable wrong");
  AST_NEG_OT:
    assert property (NEG_OVERTRAVEL_INPUT_EN == !EFFECTIVE.limit_config[1])
    else $error("negative overtravel enable wrong");
  AST_POS_SOFT:
    assert property (POS_SOFTWARE_LIMIT_EN == EFFECTIVE.limit_config[4])
    else $error("positive soft limit enable wrong");
  AST_NEG_SOFT:
    assert property (NEG_SOFTWARE_LIMIT_EN == EFFECTIVE.limit_config[5])
    else $error("negative soft limit enable wrong");
  AST_FORCE_CLIP:
    assert property (REQ.rd && REQ.idx == IDX_PEAK_FORCE |=>
      RSP_VALID && RSP_RDATA == $past(clip))
    else $error("peak force read wrong");
  AST_RSVD_ZERO:
    assert property (REQ.rd && REQ.idx == IDX_RSVD_AFTER_FWD |=>
      RSP_VALID && RSP_RDATA == RSVD_VALUE)
    else $error("reserved word not zero");
  AST_ANSWER:
    assert property ((REQ.wr || REQ.rd) |=> RSP_VALID)
    else $error("request not answered next cycle");
  AST_ONE_SHOT:
    assert property (!(REQ.wr || REQ.rd) |=> !RSP_VALID)
    else $error("answer without request");
endmodule
bind scpb_param_bank scpb_monitor mon_u (
  .CLK(CLK), .RESET(RESET), .REQ(REQ), .CONFIG_CMD(CONFIG_CMD),
  .DEV_INFO(DEV_INFO), .RSP_VALID(RSP_VALID), .RSP_STATUS(RSP_STATUS),
  .RSP_RDATA(RSP_RDATA), .EFFECTIVE(EFFECTIVE),
  .ORIGIN_OFFSET(ORIGIN_OFFSET),
  .POS_OVERTRAVEL_INPUT_EN(POS_OVERTRAVEL_INPUT_EN),
  .NEG_OVERTRAVEL_INPUT_EN(NEG_OVERTRAVEL_INPUT_EN),
  .POS_SOFTWARE_LIMIT_EN(POS_SOFTWARE_LIMIT_EN),
  .NEG_SOFTWARE_LIMIT_EN(NEG_SOFTWARE_LIMIT_EN)
);

// >>> scpb_host_model.sv
`timescale 1ns/100ps
// ********
// host controller on the parameter link
// ********
module scpb_host_model
  import scpb_pkg::*;
(
  input  wire logic                   CLK,
  output scpb_pkg::scpb_req_t         REQ,
  input  wire logic                   RSP_VALID,
  input  wire scpb_pkg::scpb_status_t RSP_STATUS,
  input  wire logic [31:0]            RSP_RDATA
);
  initial REQ = '0;
  // all parameter changes come through here, one request at a time
  task automatic access(input logic w, input logic [7:0] i,
    input logic [31:0] d, output scpb_status_t st, output logic [31:0] q);
    logic got;
    got = 1'b0;
    @(posedge CLK);
    REQ <= '{wr: w, rd: !w, idx: i, wdata: d};
    @(posedge CLK);
    // idle fields flip so a stale value is never mistaken for a request
    REQ <= '{wr: 1'b0, rd: 1'b0, idx: ~i, wdata: ~d};
    for (int k = 0; k < 4 && !got; k++) begin
      @(posedge CLK);
      got = RSP_VALID === 1'b1;
    end
    st = RSP_STATUS;
    q = got ? RSP_RDATA : 'x;
  endtask
endmodule

// >>> tb.sv
`timescale 1ns/100ps
// ********
// parameter bank bench
// ********
module tb;
  import scpb_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              cfg = 1'b0;
  scpb_req_t         req;
  scpb_dev_info_t    info = '{32'h1, 32'h1, 32'h1388, 32'h1770, 32'h3,
                              32'h64, 32'hffff_fff0, 32'h5, 32'h800};
  logic              rv;
  scpb_status_t      rs;
  logic [31:0]       rd;
  scpb_restart_set_t eff;
  logic [31:0]       org;
  logic [31:0]       fwd;
  wire [3:0]         en;
  int                n_fail = 0;
  int                compares = 0;
  int                cyc = 0;
  always #50 clk = ~clk;
  scpb_param_bank dut_u (
    .CLK(clk), .RESET(rst), .REQ(req), .CONFIG_CMD(cfg), .DEV_INFO(info),
    .RSP_VALID(rv), .RSP_STATUS(rs), .RSP_RDATA(rd), .EFFECTIVE(eff),
    .ORIGIN_OFFSET(org), .FWD_SOFT_LIMIT(fwd),
    .POS_OVERTRAVEL_INPUT_EN(en[3]), .NEG_OVERTRAVEL_INPUT_EN(en[2]),
    .POS_SOFTWARE_LIMIT_EN(en[1]), .NEG_SOFTWARE_LIMIT_EN(en[0]));
  scpb_host_model host_u (.CLK(clk), .REQ(req), .RSP_VALID(rv),
    .RSP_STATUS(rs), .RSP_RDATA(rd));
  task automatic close_out;
    if (n_fail == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_st(input scpb_status_t e, g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH status exp %0d got %0d", e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] i,
    input logic [31:0] d, input scpb_status_t es, input logic [31:0] eq);
    scpb_status_t st;
    logic [31:0] q;
    host_u.access(w, i, d, st, q);
    chk_st(es, st);
    chk($sformatf("rdata %h", i), eq, q);
  endtask
  task automatic chk_cfg(input logic [31:0] p, g, d, l);
    chk("pitch", p, eff.scale_pitch);
    chk("gear_num", g, eff.gear_num);
    chk("gear_den", d, eff.gear_den);
    chk("limit", l, eff.limit_config);
    chk("enables", {28'h0, ~l[0], ~l[1], l[4], l[5]}, {28'h0, en});
  endtask
  task automatic t_reset;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_cfg(RST_SCALE_PITCH, RST_GEAR, RST_GEAR, RST_LIMIT_CONFIG);
    chk("origin", RST_ORIGIN_OFFSET, org);
    chk("fwd_limit", RST_FWD_SOFT_LIMIT, fwd);
    acc(1'b0, IDX_GEAR_DEN, '0, RSP_OK, RST_GEAR);
  endtask
  task automatic t_info;
    logic [7:0] ix;
    logic [31:0] ex [10];
    ex = '{RST_ENCODER_KIND, info.motor_kind, info.loop_kind,
      info.rated_speed, info.peak_speed, info.speed_scale, info.rated_force,
      FORCE_MAX, info.force_scale, info.pulses_pitch};
    for (int k = 0; k < 10; k++) begin
      ix = (k < 9) ? 8'(k + 1) : IDX_PULSES_PITCH;
      acc(1'b0, ix, '0, RSP_OK, ex[k]);
      acc(1'b1, ix, ~ex[k], RSP_READ_ONLY, '0);
      acc(1'b0, ix, '0, RSP_OK, ex[k]);
    end
    acc(1'b1, 8'h0a, '1, RSP_UNMAPPED, '0);
    acc(1'b0, IDX_RSVD_AFTER_FWD, '0, RSP_OK, RSVD_VALUE);
  endtask
  task automatic t_restart;
    logic [7:0] ix [4];
    logic [31:0] v [2][4];
    logic [31:0] o [4];
    ix = '{IDX_SCALE_PITCH, IDX_GEAR_NUM, IDX_GEAR_DEN, IDX_LIMIT_CONFIG};
    v = '{'{PITCH_MAX, 32'h5, GEAR_MAX, 32'h33},
      '{32'ha, GEAR_MAX, GEAR_MIN, 32'h12}};
    o = '{RST_SCALE_PITCH, RST_GEAR, RST_GEAR, RST_LIMIT_CONFIG};
    for (int r = 0; r < 2; r++) begin
      for (int j = 0; j < 4; j++)
        acc(1'b1, ix[j], v[r][j], RSP_OK, '0);
      for (int j = 0; j < 4; j++)
        acc(1'b0, ix[j], '0, RSP_OK, v[r][j]);
      chk_cfg(o[0], o[1], o[2], o[3]);
      cfg <= 1'b1;
      @(posedge clk);
      cfg <= 1'b0;
      repeat (3) @(posedge clk);
      o = v[r];
      chk_cfg(o[0], o[1], o[2], o[3]);
    end
  endtask
  task automatic t_range;
    logic [7:0] ix [6];
    logic [31:0] d [6];
    ix = '{IDX_GEAR_NUM, IDX_GEAR_DEN, IDX_SCALE_PITCH, IDX_SCALE_PITCH,
      IDX_LIMIT_CONFIG, IDX_ORIGIN_OFFSET};
    d = '{32'h0, GEAR_MAX + 1, PITCH_MAX + 10, 32'hf, 32'h4, SIGNED_MAX + 1};
    acc(1'b1, IDX_ORIGIN_OFFSET, SIGNED_MIN, RSP_OK, '0);
    acc(1'b1, IDX_FWD_SOFT_LIMIT, SIGNED_MIN, RSP_OK, '0);
    @(posedge clk);
    chk("origin", SIGNED_MIN, org);
    chk("fwd_limit", SIGNED_MIN, fwd);
    for (int k = 0; k < 6; k++)
      acc(1'b1, ix[k], d[k], RSP_RANGE, '0);
    acc(1'b1, IDX_FWD_SOFT_LIMIT, SIGNED_MAX + 1, RSP_RANGE, '0);
    acc(1'b0, IDX_GEAR_NUM, '0, RSP_OK, GEAR_MAX);
    acc(1'b0, IDX_GEAR_DEN, '0, RSP_OK, GEAR_MIN);
    acc(1'b0, IDX_SCALE_PITCH, '0, RSP_OK, 32'ha);
    // let a wrongly taken write reach the output register before looking
    @(posedge clk);
    chk("origin", SIGNED_MIN, org);
    chk("fwd_limit", SIGNED_MIN, fwd);
  endtask
  initial begin
    t_reset();
    t_info();
    t_restart();
    t_range();
    t_reset();
    close_out();
  end
endmodule
